/* hdl/swtv_ctrl.sv */
/*
  sleep, wake and trap vector control beside a small core: the system sleep
  control register, the interrupt system config and trap vector csrs, wake
  logic for event and interrupt waits, and low-power mode requests.
  assumes the core gives one-cycle wait/return pulses and csr requests on
  ref_clk; irq pending and enable vectors are same-clock levels.
*/
`include "swtv_consts.svh"
// Overview of operation
// - writing one to bit 31 pulses whole-chip reset; bit self-clears; zero does nothing
// - writing one to bit 5 raises a wake event releasing an event wait
// - pending_irq_wakes set: enabled events and any pending interrupt wake an event wait
// - pending_irq_wakes clear: only enabled events wake an event wait, only enabled interrupts an interrupt wait
// - a wake before any event wait is remembered; next wait finishes at once
// - bit 3 set makes every wait-for-interrupt instruction behave as an event wait; the sleep on return still waits for an interrupt
// - bit 2 picks deep sleep (one) or ordinary sleep (zero)
// - bit 1 set enters low power on handler return, else resume main
// - vendor csrs live in a 12-bit csr address space
// - vendor csrs are reachable only in machine mode
// - bit 1 of csr 0x804 enables nesting, resets to zero
// - bit 0 of csr 0x804 enables hardware context saving, resets to zero
// - trap vector csr 0x305 bits 31:2 hold the table base, read-write
// - trap vector bit 1 selects jump-instruction or absolute-address entries
// - trap vector bit 0 selects common entry or, for interrupts only, base plus number times four
// - with nesting, bit 7 of each priority byte is the preemption bit
module swtv_ctrl #(
  parameter int NIRQ = `SWTV_NIRQ
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire swtv_pkg::swtv_csr_req_s csr_req,
  output logic [31:0] csr_rdata_ff,
  output logic csr_ack_ff,
  output logic csr_err_ff,
  input wire logic sctl_we,
  input wire logic sctl_re,
  input wire logic [7:0] sctl_addr,
  input wire logic [31:0] sctl_wdata,
  output logic [31:0] sctl_rdata_ff,
  input wire swtv_pkg::swtv_core_ev_s core_ev,
  input wire logic ext_event,
  input wire logic [NIRQ-1:0] irq_pend,
  input wire logic [NIRQ-1:0] irq_en,
  input wire logic [NIRQ-1:0][7:0] irq_prio,
  input wire logic trap_is_irq,
  input wire logic [$clog2(NIRQ)-1:0] trap_num,
  output logic [31:0] trap_entry_ff,
  output logic entry_is_addr_ff,
  output logic [NIRQ-1:0] preempt_ff,
  output logic nest_en_ff,
  output logic hw_save_en_ff,
  output logic sys_reset_req_ff,
  output logic core_release_ff,
  output logic core_stalled_ff,
  output swtv_pkg::swtv_pwr_e pwr_mode_ff
);
  import swtv_pkg::*;

  if (NIRQ < 2 || NIRQ > 256)
  begin : g_nirq_chk
    $error("swtv_ctrl: NIRQ out of range");
  end

  // control register fields
  logic pend_wake_ff;
  logic wfi_as_wfe_ff;
  logic deep_sel_ff;
  logic exit_sleep_ff;
  logic [31:0] tvec_ff;
  logic [2:0] rst_cnt_ff;
  logic evt_latch_ff;
  logic wait_evt_ff;
  logic wait_irq_ff;
  logic evt_meta_ff;
  logic evt_sync_ff;

  logic sctl_hit;
  logic csr_ok;
  logic csr_wr;
  logic any_irq_wake;
  logic wake_evt;
  logic evt_wait_cmd;
  logic irq_wait_cmd;
  logic wake_any;

  assign sctl_hit = (sctl_addr == `SWTV_SCTL_ADDR);
  // vendor csrs answer only in machine mode; other modes get an error
  assign csr_ok = csr_req.mmode;
  assign csr_wr = csr_req.req && csr_req.we && csr_ok;

  // the external event may come from a pin: two flops before any logic reads it,
  // which costs two cycles of wake latency but keeps metastability out of the latch
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      evt_meta_ff <= 1'b0;
      evt_sync_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      evt_meta_ff <= ext_event;
      evt_sync_ff <= evt_meta_ff;
    end
  end

  // wake sources: with pending wakes on, any pending irq counts
  always_comb
  begin
    if (pend_wake_ff)
      any_irq_wake = |irq_pend;
    else
      any_irq_wake = |(irq_pend & irq_en);
  end

  assign wake_evt = evt_sync_ff
    || (sctl_we && sctl_hit && sctl_wdata[`SWTV_SCTL_EVT_BIT])
    || (pend_wake_ff && any_irq_wake);

  // an interrupt wait turns into an event wait under bit 3
  assign evt_wait_cmd = core_ev.wait_for_event_instr || (core_ev.wfi && wfi_as_wfe_ff);
  assign irq_wait_cmd = core_ev.wfi && !wfi_as_wfe_ff;
  assign wake_any = (wait_evt_ff && (wake_evt || evt_latch_ff))
    || (wait_irq_ff && |(irq_pend & irq_en));

  // system sleep control register bits
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pend_wake_ff <= 1'b0;
      wfi_as_wfe_ff <= 1'b0;
      deep_sel_ff <= 1'b0;
      exit_sleep_ff <= 1'b0;
    end
    else if (clk_en && sctl_we && sctl_hit)
    begin
      pend_wake_ff <= sctl_wdata[`SWTV_SCTL_PEND_BIT];
      wfi_as_wfe_ff <= sctl_wdata[`SWTV_SCTL_W2E_BIT];
      deep_sel_ff <= sctl_wdata[`SWTV_SCTL_DEEP_BIT];
      exit_sleep_ff <= sctl_wdata[`SWTV_SCTL_EXIT_BIT];
    end
  end

  // reset request: stretched pulse, nothing stored so reads see zero
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rst_cnt_ff <= 3'h0;
      sys_reset_req_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sctl_we && sctl_hit && sctl_wdata[`SWTV_SCTL_RST_BIT])
        rst_cnt_ff <= 3'(`SWTV_RST_PULSE_CYC);
      else if (rst_cnt_ff != 3'h0)
        rst_cnt_ff <= rst_cnt_ff - 3'h1;
      sys_reset_req_ff <= (sctl_we && sctl_hit && sctl_wdata[`SWTV_SCTL_RST_BIT])
        || (rst_cnt_ff > 3'h1);
    end
  end

  // remembered event: set wins over consume in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      evt_latch_ff <= 1'b0;
    else if (clk_en)
    begin
      // a new event meeting a wait that eats the old one stays remembered
      if (wake_evt && !wait_evt_ff && (!evt_wait_cmd || evt_latch_ff))
        evt_latch_ff <= 1'b1;
      else if (evt_wait_cmd && evt_latch_ff)
        evt_latch_ff <= 1'b0;
      else if (wait_evt_ff && evt_latch_ff)
        evt_latch_ff <= 1'b0;
    end
  end

  // wait tracking and low-power mode
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wait_evt_ff <= 1'b0;
      wait_irq_ff <= 1'b0;
      core_release_ff <= 1'b0;
      core_stalled_ff <= 1'b0;
      pwr_mode_ff <= SWTV_RUN;
    end
    else if (clk_en)
    begin
      core_release_ff <= 1'b0;
      if (wake_any)
      begin
        wait_evt_ff <= 1'b0;
        wait_irq_ff <= 1'b0;
        core_release_ff <= 1'b1;
        core_stalled_ff <= 1'b0;
        pwr_mode_ff <= SWTV_RUN;
      end
      else if (evt_wait_cmd && (evt_latch_ff || wake_evt))
        core_release_ff <= 1'b1;
      else if (evt_wait_cmd || irq_wait_cmd || (core_ev.mret && exit_sleep_ff))
      begin
        wait_evt_ff <= evt_wait_cmd;
        wait_irq_ff <= irq_wait_cmd || core_ev.mret;
        core_stalled_ff <= 1'b1;
        pwr_mode_ff <= deep_sel_ff ? SWTV_DEEP : SWTV_SLEEP;
      end
    end
  end

  // sleep control read-back: reset and event bits are write-only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      sctl_rdata_ff <= `SWTV_RESET_WORD;
    else if (clk_en && sctl_re)
    begin
      sctl_rdata_ff <= `SWTV_RESET_WORD;
      if (sctl_hit)
      begin
        sctl_rdata_ff[`SWTV_SCTL_PEND_BIT] <= pend_wake_ff;
        sctl_rdata_ff[`SWTV_SCTL_W2E_BIT] <= wfi_as_wfe_ff;
        sctl_rdata_ff[`SWTV_SCTL_DEEP_BIT] <= deep_sel_ff;
        sctl_rdata_ff[`SWTV_SCTL_EXIT_BIT] <= exit_sleep_ff;
      end
    end
  end

  // csr writes, machine mode only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      nest_en_ff <= 1'b0;
      hw_save_en_ff <= 1'b0;
      tvec_ff <= `SWTV_RESET_WORD;
    end
    else if (clk_en && csr_wr)
    begin
      if (csr_req.addr == `SWTV_CSR_ISCFG)
      begin
        nest_en_ff <= csr_req.wdata[`SWTV_ISC_NEST_BIT];
        hw_save_en_ff <= csr_req.wdata[`SWTV_ISC_HWS_BIT];
      end
      if (csr_req.addr == `SWTV_CSR_TVEC)
        tvec_ff <= csr_req.wdata;
    end
  end

  // csr reads and answers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      csr_rdata_ff <= `SWTV_RESET_WORD;
      csr_ack_ff <= 1'b0;
      csr_err_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      csr_ack_ff <= csr_req.req && csr_ok;
      csr_err_ff <= csr_req.req && !csr_ok;
      csr_rdata_ff <= `SWTV_RESET_WORD;
      if (csr_req.req && csr_ok && csr_req.addr == `SWTV_CSR_ISCFG)
      begin
        csr_rdata_ff[`SWTV_ISC_NEST_BIT] <= nest_en_ff;
        csr_rdata_ff[`SWTV_ISC_HWS_BIT] <= hw_save_en_ff;
      end
      else if (csr_req.req && csr_ok && csr_req.addr == `SWTV_CSR_TVEC)
        csr_rdata_ff <= tvec_ff;
    end
  end

  // entry form flag and per-interrupt preemption bit
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      entry_is_addr_ff <= 1'b0;
    else if (clk_en)
      entry_is_addr_ff <= tvec_ff[`SWTV_TV_FORM_BIT];
  end

  for (genvar i = 0; i < NIRQ; i++)
  begin : g_pre
    always_ff @(posedge ref_clk)
    begin
      if (!nrst)
        preempt_ff[i] <= 1'b0;
      else if (clk_en)
        preempt_ff[i] <= nest_en_ff && irq_prio[i][`SWTV_PRIO_PREEMPT_BIT];
    end
  end

  swtv_irq_vec #(
    .NIRQ(NIRQ)
  ) u_vec (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .tvec(tvec_ff),
    .is_irq(trap_is_irq),
    .irq_num(trap_num),
    .entry_addr_ff(trap_entry_ff)
  );
endmodule

/* hdl/swtv_consts.svh */
/*
  offsets, field positions, reset values and widths of the sleep, wake and
  trap vector control block. assumes inclusion by bare name from hdl/.
*/
`ifndef SWTV_CONSTS_SVH
`define SWTV_CONSTS_SVH
`define SWTV_CSR_AW 12
`define SWTV_CSR_TVEC 12'h305
`define SWTV_CSR_ISCFG 12'h804
`define SWTV_SCTL_ADDR 8'h10
`define SWTV_SCTL_RST_BIT 31
`define SWTV_SCTL_EVT_BIT 5
`define SWTV_SCTL_PEND_BIT 4
`define SWTV_SCTL_W2E_BIT 3
`define SWTV_SCTL_DEEP_BIT 2
`define SWTV_SCTL_EXIT_BIT 1
`define SWTV_ISC_NEST_BIT 1
`define SWTV_ISC_HWS_BIT 0
`define SWTV_TV_FORM_BIT 1
`define SWTV_TV_SEL_BIT 0
`define SWTV_PRIO_PREEMPT_BIT 7
`define SWTV_RESET_WORD 32'h00000000
`define SWTV_NIRQ 32
`define SWTV_RST_PULSE_CYC 4
`endif

/* hdl/swtv_pkg.sv */
/*
  types shared by the sleep, wake and trap vector control block.
  assumes the constants header sits beside it.
*/
package swtv_pkg;
  typedef enum logic [2:0] {
    SWTV_RUN = 3'h1,
    SWTV_SLEEP = 3'h2,
    SWTV_DEEP = 3'h4
  } swtv_pwr_e;

  typedef struct packed {
    logic wfi;
    logic wait_for_event_instr;
    logic mret;
  } swtv_core_ev_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic mmode;
  } swtv_csr_req_s;
endpackage

/* hdl/swtv_irq_vec.sv */
/*
  trap entry address former: picks the entry slot from the vector base and
  the interrupt number. assumes same-clock inputs; output is registered.
*/
`include "swtv_consts.svh"
module swtv_irq_vec #(
  parameter int NIRQ = `SWTV_NIRQ
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [31:0] tvec,
  input wire logic is_irq,
  input wire logic [$clog2(NIRQ)-1:0] irq_num,
  output logic [31:0] entry_addr_ff
);
  if (NIRQ < 2 || NIRQ > 256)
  begin : g_nirq_chk
    $error("swtv_irq_vec: NIRQ out of range");
  end

  logic [31:0] base;
  logic [31:0] nxt_entry_addr;

  always_comb
  begin
    base = {tvec[31:2], 2'b00};
    // offset by number*4 only in the per-interrupt mode, and only for interrupts
    if (tvec[`SWTV_TV_SEL_BIT] && is_irq)
      nxt_entry_addr = base + {{(30 - $clog2(NIRQ)){1'b0}}, irq_num, 2'b00};
    else
      nxt_entry_addr = base;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      entry_addr_ff <= `SWTV_RESET_WORD;
    else if (clk_en)
      entry_addr_ff <= nxt_entry_addr;
  end
endmodule

/* sim/swtv_ctrl_monitor.sv */
/*
  checker for the sleep, wake and trap vector control block.
  assumes it is bound to swtv_ctrl and sees only its ports.
*/
`include "swtv_consts.svh"
module swtv_ctrl_monitor
  import swtv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire swtv_pkg::swtv_csr_req_s csr_req,
  input wire logic csr_ack_ff,
  input wire logic csr_err_ff,
  input wire logic sctl_we,
  input wire logic [7:0] sctl_addr,
  input wire logic [31:0] sctl_wdata,
  input wire logic nest_en_ff,
  input wire logic hw_save_en_ff,
  input wire logic sys_reset_req_ff,
  input wire logic core_release_ff,
  input wire logic core_stalled_ff,
  input wire swtv_pkg::swtv_pwr_e pwr_mode_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic csr_go;
  logic isc_wr;
  assign csr_go = clk_en && csr_req.req;
  assign isc_wr = csr_go && csr_req.we && csr_req.mmode && csr_req.addr == `SWTV_CSR_ISCFG;
  sequence s_rst_wr;
    clk_en && sctl_we && sctl_addr == `SWTV_SCTL_ADDR && sctl_wdata[31];
  endsequence
  sequence s_rst_pulse;
    sys_reset_req_ff [*4] ##1 !sys_reset_req_ff;
  endsequence
  AST_RST_PULSE: assert property (s_rst_wr |=> s_rst_pulse)
    else $error("reset request pulse wrong");
  AST_RST_CAUSE: assert property ($rose(sys_reset_req_ff) |-> $past(sctl_wdata[31]))
    else $error("reset request without a write of one");
  AST_CSR_ERR: assert property (csr_go && !csr_req.mmode |=> csr_err_ff && !csr_ack_ff)
    else $error("csr access outside machine mode not refused");
  AST_CSR_ACK: assert property (csr_go && csr_req.mmode |=> csr_ack_ff && !csr_err_ff)
    else $error("machine mode csr access not acknowledged");
  AST_NEST: assert property (isc_wr |=> nest_en_ff == $past(csr_req.wdata[1]))
    else $error("nesting enable not written");
  AST_HWS: assert property (isc_wr |=> hw_save_en_ff == $past(csr_req.wdata[0]))
    else $error("context save enable not written");
  AST_CFG_HOLD: assert property (!isc_wr |=> $stable({nest_en_ff, hw_save_en_ff}))
    else $error("config bits changed without a write");
  AST_WAKE: assert property (nrst && $past(nrst) && $fell(core_stalled_ff)
    |-> core_release_ff && pwr_mode_ff == SWTV_RUN)
    else $error("wake without release or run mode");
  AST_STALL_MODE: assert property (core_stalled_ff |-> pwr_mode_ff != SWTV_RUN)
    else $error("stalled core in run mode");
  AST_REL_ONCE: assert property (core_release_ff |=> !core_release_ff)
    else $error("release longer than one cycle");
endmodule

bind swtv_ctrl swtv_ctrl_monitor u_mon (.ref_clk, .nrst, .clk_en, .csr_req, .csr_ack_ff,
  .csr_err_ff, .sctl_we, .sctl_addr, .sctl_wdata, .nest_en_ff, .hw_save_en_ff,
  .sys_reset_req_ff, .core_release_ff, .core_stalled_ff, .pwr_mode_ff);

/* sim/swtv_core_model.sv */
/*
  model of the core: issues csr accesses and wait or return pulses.
  assumes the bench calls its tasks and that ref_clk runs.
*/
module swtv_core_model
  import swtv_pkg::*;
(
  input wire logic ref_clk,
  output swtv_pkg::swtv_csr_req_s csr_req,
  output swtv_pkg::swtv_core_ev_s core_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    csr_req = '0;
    core_ev = '0;
  end
  task automatic csr(input logic we, input logic mm, input logic [11:0] a,
    input logic [31:0] d);
    @(negedge ref_clk);
    csr_req = '{1'b1, we, a, d, mm};
    @(negedge ref_clk);
    // released fields show junk, never the last value
    csr_req = '{1'b0, ~we, ~a, ~d, ~mm};
  endtask
  task automatic instr(input swtv_core_ev_s ev);
    @(negedge ref_clk);
    core_ev = ev;
    @(negedge ref_clk);
    core_ev = '0;
  endtask
endmodule

/* sim/tb.sv */
/*
  testbench of the sleep, wake and trap vector control block.
  assumes the core model and checker files are compiled before it.
*/
module tb;
  import swtv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic sctl_we = 1'b0;
  logic sctl_re = 1'b0;
  logic [7:0] sctl_addr = 8'h10;
  logic [31:0] sctl_wdata = 32'h0;
  logic ext_event = 1'b0;
  logic [31:0] irq_pend = 32'h0;
  logic [31:0] irq_en = 32'h0;
  logic [31:0][7:0] irq_prio = '0;
  logic trap_is_irq = 1'b0;
  logic [4:0] trap_num = 5'h0;
  swtv_csr_req_s csr_req;
  swtv_core_ev_s core_ev;
  logic [31:0] csr_rdata_ff, sctl_rdata_ff, trap_entry_ff, preempt_ff;
  logic csr_ack_ff, csr_err_ff, entry_is_addr_ff, nest_en_ff, hw_save_en_ff;
  logic sys_reset_req_ff, core_release_ff, core_stalled_ff;
  swtv_pwr_e pwr_mode_ff;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  swtv_core_model u_core (.ref_clk, .csr_req, .core_ev);
  swtv_ctrl u_dut (.ref_clk, .nrst, .clk_en, .csr_req, .csr_rdata_ff, .csr_ack_ff,
    .csr_err_ff, .sctl_we, .sctl_re, .sctl_addr, .sctl_wdata, .sctl_rdata_ff, .core_ev,
    .ext_event, .irq_pend, .irq_en, .irq_prio, .trap_is_irq, .trap_num, .trap_entry_ff,
    .entry_is_addr_ff, .preempt_ff, .nest_en_ff, .hw_save_en_ff, .sys_reset_req_ff,
    .core_release_ff, .core_stalled_ff, .pwr_mode_ff);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hang is cut here; the tests need well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw(input logic [31:0] d);
    @(negedge ref_clk);
    sctl_we = 1'b1;
    sctl_wdata = d;
    @(negedge ref_clk);
    sctl_we = 1'b0;
    sctl_wdata = ~d;
  endtask
  task automatic srd(input logic [31:0] exp);
    @(negedge ref_clk);
    sctl_re = 1'b1;
    @(negedge ref_clk);
    sctl_re = 1'b0;
    chk(sctl_rdata_ff, exp);
  endtask
  task automatic crd(input logic [11:0] a, input logic [31:0] exp);
    u_core.csr(1'b0, 1'b1, a, 32'h0);
    chk(csr_rdata_ff, exp);
    chk({31'h0, csr_ack_ff}, 32'h1);
  endtask
  // the release pulse may land in this cycle or either of the next two
  task automatic wrel(input logic exp);
    logic s;
    s = core_release_ff;
    repeat (2)
    begin
      @(negedge ref_clk);
      s = s | core_release_ff;
    end
    chk({31'h0, s}, {31'h0, exp});
  endtask
  task automatic irq(input logic p, input logic e);
    @(negedge ref_clk);
    irq_pend[2] = p;
    irq_en[2] = e;
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    crd(12'h804, 32'h0);
    crd(12'h305, 32'h0);
    srd(32'h0);
    sctl_addr = 8'h14;
    sw(32'h0000001E);
    srd(32'h0);
    sctl_addr = 8'h10;
    srd(32'h0);
    u_core.csr(1'b1, 1'b1, 12'h804, 32'h3);
    chk({nest_en_ff, hw_save_en_ff}, 32'h3);
    u_core.csr(1'b1, 1'b0, 12'h804, 32'h0);
    chk(csr_err_ff, 32'h1);
    crd(12'h804, 32'h3);
    crd(12'h123, 32'h0);
    $display("csr test done");
    u_core.csr(1'b1, 1'b1, 12'h305, 32'hFFFFFFFF);
    crd(12'h305, 32'hFFFFFFFF);
    clk_en = 1'b0;
    u_core.csr(1'b1, 1'b1, 12'h305, 32'h0);
    clk_en = 1'b1;
    crd(12'h305, 32'hFFFFFFFF);
    u_core.csr(1'b1, 1'b1, 12'h305, 32'h00001003);
    trap_is_irq = 1'b1;
    trap_num = 5'h5;
    irq_prio[3] = 8'h80;
    repeat (2) @(negedge ref_clk);
    chk(trap_entry_ff, 32'h00001014);
    chk(entry_is_addr_ff, 32'h1);
    chk(preempt_ff[3], 32'h1);
    u_core.csr(1'b1, 1'b1, 12'h305, 32'h00001000);
    u_core.csr(1'b1, 1'b1, 12'h804, 32'h0);
    repeat (2) @(negedge ref_clk);
    chk(trap_entry_ff, 32'h00001000);
    chk(entry_is_addr_ff, 32'h0);
    chk(preempt_ff[3], 32'h0);
    $display("vector test done");
    sw(32'h80000000);
    chk(sys_reset_req_ff, 32'h1);
    sw(32'h0000003E);
    srd(32'h0000001E);
    u_core.instr(3'b010);
    wrel(1'b1);
    u_core.instr(3'b100);
    wrel(1'b0);
    chk(pwr_mode_ff, SWTV_DEEP);
    irq(1'b1, 1'b0);
    wrel(1'b1);
    irq(1'b0, 1'b0);
    u_core.instr(3'b010);
    wrel(1'b1);
    sw(32'h0);
    u_core.instr(3'b100);
    chk(pwr_mode_ff, SWTV_SLEEP);
    irq(1'b1, 1'b0);
    wrel(1'b0);
    irq(1'b1, 1'b1);
    wrel(1'b1);
    irq(1'b0, 1'b0);
    u_core.instr(3'b010);
    wrel(1'b0);
    sw(32'h00000020);
    wrel(1'b1);
    u_core.instr(3'b010);
    @(negedge ref_clk);
    ext_event = 1'b1;
    @(negedge ref_clk);
    ext_event = 1'b0;
    wrel(1'b1);
    $display("wait test done");
    sw(32'h00000002);
    u_core.instr(3'b001);
    chk(core_stalled_ff, 32'h1);
    irq(1'b1, 1'b1);
    wrel(1'b1);
    irq(1'b0, 1'b0);
    sw(32'h0);
    u_core.instr(3'b001);
    wrel(1'b0);
    chk(core_stalled_ff, 32'h0);
    $display("exit test done");
    results();
  end
endmodule
